// *** rtl/bsih_map.vh ***
// constants for the backplane system control and interrupt block
// assumes one 25 MHz clock domain; all backplane pins arrive asynchronous
// Functional notes
// - only backplane interrupt levels enabled by strap are honoured, seven levels
// - an accepted interrupt first requests the bus and waits for grant
// - after grant run acknowledge cycle, pass the interrupter's vector on
// - power-fail low raises the non-maskable interrupt when that level is enabled
// - as system controller accept requests on five priority levels
// - grant goes to the highest priority pending requester
// - as system controller drive a 16 MHz clock onto the backplane
// - as system controller hold backplane reset low while board is in reset
// - as system controller raise bus fault when no slave answers a cycle
// - timeout selectable as 8, 16, 32 or 64 us, or disabled
// - arbiter, clock, reset and timeout act only when strapped as controller
// - addresses f70000 to f70019 decode to status, serial and timer space
// - status register decodes at f70018 on both byte lanes
// - address 01fff0 shows only an image of the control register
// - 32 MHz source divided to 8 MHz processor and 16 MHz backplane clock
// - read-only memory region of 64K bytes over two sockets
// - RAM parity generated and checked by option; retry, then bus fault
// - 128K byte dynamic RAM has its own refresh control
// - backplane RAM base on 1K boundaries inside a selectable 256K block
// - RAM waits: writes 0-1, reads 2-3, parity reads 3-4
// - unowned backplane access requests bus itself, releases after access
`ifndef BSIH_MAP_VH
`define BSIH_MAP_VH
`define BSIH_STATUS_ADDR   24'hf70018
`define BSIH_IO_LO_ADDR    24'hf70000
`define BSIH_IO_HI_ADDR    24'hf70019
`define BSIH_TIMER_LO_ADDR 24'hf70000
`define BSIH_TIMER_HI_ADDR 24'hf7000f
`define BSIH_SERIAL_LO     24'hf70010
`define BSIH_SERIAL_HI     24'hf70017
`define BSIH_CTRL_IMG_ADDR 24'h01fff0
`define BSIH_ROM_BASE      24'hf00000
`define BSIH_ROM_TOP       24'hf0ffff
`define BSIH_ROM_SOCK_BIT  15
`define BSIH_RAM_TOP       24'h01ffff
`define BSIH_CTRL_RESET    16'h0000
`define BSIH_CTRL_REQ_BIT  0
`define BSIH_CTRL_WP_BIT   1
`define BSIH_TMO_8_US      8
`define BSIH_CLK_MHZ       25
`define BSIH_TMO_8_CYC     (`BSIH_TMO_8_US * `BSIH_CLK_MHZ)
`define BSIH_REFRESH_CYC   375
`define BSIH_WAIT_WR       3'h1
`define BSIH_WAIT_RD       3'h2
`define BSIH_WAIT_RDP      3'h3
`endif

// *** rtl/bsih_arbiter.v ***
// priority arbiter for five backplane request levels
// assumes requests are already synchronised to mclk
module bsih_arbiter #(
  parameter LEVELS = 5
) (
  input  wire [LEVELS-1:0] req,
  input  wire              enable,
  output reg  [LEVELS-1:0] grant_next
);
  integer i;
  reg found;
  // highest index wins, one grant at most
  always @*
  begin
    grant_next = {LEVELS{1'b0}};
    found = 1'b0;
    for (i = LEVELS-1; i >= 0; i = i - 1)
    begin
      if (enable && req[i] && !found)
      begin
        grant_next[i] = 1'b1;
        found = 1'b1;
      end
    end
  end
endmodule

// *** rtl/bsih_top.v ***
// backplane system control, interrupt handling and local decode
// assumes backplane pins are asynchronous; processor bus is on mclk
`include "bsih_map.vh"
module bsih_top #(
  parameter TMO_BASE = `BSIH_TMO_8_CYC,
  parameter REF_CYC  = `BSIH_REFRESH_CYC
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        sysctl_strap,
  input  wire [6:0]  irq_level_enable,
  input  wire [2:0]  own_req_level,
  input  wire [2:0]  tmo_select,
  input  wire        parity_enable,
  input  wire [7:0]  ram_base_1k,
  input  wire [1:0]  ram_block_256k,
  input  wire [6:0]  bp_irq_n,
  input  wire        power_fail_line_n,
  input  wire [4:0]  bp_req,
  input  wire        bp_grant_in,
  input  wire        bp_ack_n,
  input  wire        bp_strobe_n,
  input  wire [7:0]  bp_data_in,
  input  wire [23:0] bp_addr,
  input  wire        cpu_strobe,
  input  wire        cpu_write,
  input  wire        cpu_offboard,
  input  wire [23:0] cpu_addr,
  input  wire [15:0] cpu_wdata,
  input  wire [1:0]  cpu_lanes,
  input  wire [15:0] board_state,
  input  wire        parity_bad,
  output reg         sys_clk_out,
  output reg         host_clk_out,
  output reg         bp_reset_n_out,
  output reg         bus_fault_signal,
  output reg  [4:0]  bp_grant_out,
  output reg         own_bus_req,
  output reg  [2:0]  own_req_lvl_out,
  output reg         iack_out,
  output reg  [2:0]  iack_level,
  output reg  [2:0]  host_irq_level,
  output reg  [7:0]  irq_vector,
  output reg         vector_valid,
  output reg  [15:0] cpu_rdata,
  output reg         cpu_ack,
  output reg         sel_status,
  output reg         sel_serial,
  output reg         sel_timer,
  output reg         sel_rom,
  output reg         rom_socket,
  output reg         sel_ram,
  output reg         ram_refresh,
  output reg         ram_bp_hit
);
  localparam ST_IDLE = 3'd0;
  localparam ST_REQ  = 3'd1;
  localparam ST_IACK = 3'd2;
  localparam ST_DONE = 3'd3;
  localparam NSYNC = 7 + 1 + 5 + 1 + 1 + 1;
  // idle pin levels, so leaving reset shows no false edge
  localparam [NSYNC-1:0] SYNC_IDLE = {7'h7f, 1'b1, 5'h00, 1'b0, 1'b1, 1'b1};

  // three-stage synchronisers, change counts when stages two and three agree
  wire [NSYNC-1:0] raw_in;
  reg  [NSYNC-1:0] s1_reg;
  reg  [NSYNC-1:0] s2_reg;
  reg  [NSYNC-1:0] s3_reg;
  reg  [NSYNC-1:0] clean_reg;
  assign raw_in = {bp_irq_n, power_fail_line_n, bp_req, bp_grant_in,
                   bp_ack_n, bp_strobe_n};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1)
    begin : sync
      always @(posedge mclk)
      begin
        if (!resetn)
        begin
          s1_reg[g] <= SYNC_IDLE[g];
          s2_reg[g] <= SYNC_IDLE[g];
          s3_reg[g] <= SYNC_IDLE[g];
          clean_reg[g] <= SYNC_IDLE[g];
        end
        else
        begin
          s1_reg[g] <= raw_in[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g])
            clean_reg[g] <= s3_reg[g];
        end
      end
    end
  endgenerate
  wire [6:0] irq_act  = ~clean_reg[15:9];
  wire       pfail    = ~clean_reg[8];
  wire [4:0] req_s    = clean_reg[7:3];
  wire       grant_s  = clean_reg[2];
  wire       ack_s    = ~clean_reg[1];
  wire       strobe_s = ~clean_reg[0];

  // clocks: 25 MHz stands for the 32 MHz source; halves and quarters it
  reg [1:0] div_reg;
  always @(posedge mclk)
  begin
    if (!resetn)
      div_reg <= 2'h0;
    else
      div_reg <= div_reg + 2'h1;
  end

  // system controller outputs: clock, reset, arbiter
  wire [4:0] grant_next;
  bsih_arbiter #(
    .LEVELS (5)
  ) u_arb (
    .req        (req_s),
    .enable     (sysctl_strap),
    .grant_next (grant_next)
  );
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      sys_clk_out    <= 1'b0;
      host_clk_out   <= 1'b0;
      bp_reset_n_out <= 1'b1;
      bp_grant_out   <= 5'h00;
    end
    else
    begin
      sys_clk_out    <= sysctl_strap & div_reg[0];
      host_clk_out   <= div_reg[1];
      bp_reset_n_out <= ~(sysctl_strap & ~board_state[0]);
      bp_grant_out   <= grant_next;
    end
  end

  // bus timeout counter, restarted per backplane strobe
  reg  [13:0] tmo_cnt_reg;
  reg  [13:0] tmo_limit;
  reg         strobe_d_reg;
  reg         tmo_fault_reg;
  always @*
  begin
    case (tmo_select[1:0])
      2'd0:    tmo_limit = TMO_BASE[13:0];
      2'd1:    tmo_limit = TMO_BASE[12:0] * 14'd2;
      2'd2:    tmo_limit = TMO_BASE[11:0] * 14'd4;
      default: tmo_limit = TMO_BASE[10:0] * 14'd8;
    endcase
  end
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      tmo_cnt_reg   <= 14'h0000;
      strobe_d_reg  <= 1'b0;
      tmo_fault_reg <= 1'b0;
    end
    else
    begin
      strobe_d_reg <= strobe_s;
      if (strobe_s && !strobe_d_reg)
      begin
        tmo_cnt_reg   <= 14'h0000;
        tmo_fault_reg <= 1'b0;
      end
      else if (!strobe_s || ack_s)
        tmo_fault_reg <= 1'b0;
      else if (sysctl_strap && !tmo_select[2])
      begin
        if (tmo_cnt_reg >= tmo_limit - 14'h0001)
          tmo_fault_reg <= 1'b1;
        else
          tmo_cnt_reg <= tmo_cnt_reg + 14'h0001;
      end
    end
  end

  // interrupt handler sequence: request, acknowledge, vector
  reg [2:0] ih_state_reg;
  reg [2:0] best_lvl;
  integer k;
  always @*
  begin
    best_lvl = 3'd0;
    for (k = 0; k < 7; k = k + 1)
    begin
      if (irq_act[k] && irq_level_enable[k])
        best_lvl = k[2:0] + 3'd1;
    end
  end
  // off-board cycle request handling
  reg cpu_own_reg;
  reg [15:0] ctrl_reg;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      ih_state_reg   <= ST_IDLE;
      iack_out       <= 1'b0;
      iack_level     <= 3'd0;
      irq_vector     <= 8'h00;
      vector_valid   <= 1'b0;
      host_irq_level <= 3'd0;
      cpu_own_reg    <= 1'b0;
    end
    else
    begin
      vector_valid <= 1'b0;
      if (pfail && irq_level_enable[6])
        host_irq_level <= 3'd7;
      else
        host_irq_level <= best_lvl;
      cpu_own_reg <= cpu_strobe & cpu_offboard; // held until access ends
      case (ih_state_reg)
        ST_IDLE:
          if (best_lvl != 3'd0)
          begin
            iack_level   <= best_lvl;
            ih_state_reg <= ST_REQ;
          end
        ST_REQ:
          if (grant_s)
          begin
            iack_out     <= 1'b1;
            ih_state_reg <= ST_IACK;
          end
        ST_IACK:
          if (ack_s)
          begin
            irq_vector   <= bp_data_in;
            vector_valid <= 1'b1;
            iack_out     <= 1'b0;
            ih_state_reg <= ST_DONE;
          end
          else if (tmo_fault_reg)
          begin
            iack_out     <= 1'b0;
            ih_state_reg <= ST_DONE;
          end
        ST_DONE:
          if (!ack_s)
            ih_state_reg <= ST_IDLE;
        default:
          ih_state_reg <= ST_IDLE;
      endcase
    end
  end

  // bus request output and level
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      own_bus_req     <= 1'b0;
      own_req_lvl_out <= 3'd0;
    end
    else
    begin
      own_bus_req <= (ih_state_reg == ST_REQ) || (ih_state_reg == ST_IACK)
                     || cpu_own_reg || ctrl_reg[`BSIH_CTRL_REQ_BIT];
      own_req_lvl_out <= own_req_level;
    end
  end

  // local address decode
  wire hit_io     = (cpu_addr >= `BSIH_IO_LO_ADDR) && (cpu_addr <= `BSIH_IO_HI_ADDR);
  wire hit_status = hit_io && (cpu_addr[23:1] == `BSIH_STATUS_ADDR >> 1);
  wire hit_img    = (cpu_addr[23:1] == `BSIH_CTRL_IMG_ADDR >> 1);
  wire hit_rom    = (cpu_addr >= `BSIH_ROM_BASE) && (cpu_addr <= `BSIH_ROM_TOP);
  wire hit_ram    = (cpu_addr <= `BSIH_RAM_TOP) && !hit_img;
  reg        img_sel_reg;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      sel_status <= 1'b0;
      sel_serial <= 1'b0;
      sel_timer  <= 1'b0;
      sel_rom    <= 1'b0;
      rom_socket <= 1'b0;
      sel_ram    <= 1'b0;
      img_sel_reg <= 1'b0;
      ctrl_reg   <= `BSIH_CTRL_RESET;
    end
    else
    begin
      sel_status <= cpu_strobe && hit_status && (cpu_lanes != 2'b00);
      sel_serial <= cpu_strobe && hit_io && (cpu_addr >= `BSIH_SERIAL_LO)
                    && (cpu_addr <= `BSIH_SERIAL_HI);
      sel_timer  <= cpu_strobe && hit_io && (cpu_addr <= `BSIH_TIMER_HI_ADDR);
      sel_rom    <= cpu_strobe && hit_rom && !cpu_write;
      rom_socket <= cpu_addr[`BSIH_ROM_SOCK_BIT];
      sel_ram    <= cpu_strobe && hit_ram;
      img_sel_reg <= cpu_strobe && hit_img;
      if (cpu_strobe && hit_img && cpu_write)
        ctrl_reg <= cpu_wdata;
    end
  end

  // backplane RAM window: 1K base within 256K block
  always @(posedge mclk)
  begin
    if (!resetn)
      ram_bp_hit <= 1'b0;
    else
      ram_bp_hit <= strobe_s && (bp_addr[23:18] == {4'h0, ram_block_256k})
                    && (bp_addr[17:10] >= ram_base_1k)
                    && ({1'b0, bp_addr[17:10]} < {1'b0, ram_base_1k} + 9'd128);
  end

  // refresh timer
  reg [9:0] ref_cnt_reg;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      ref_cnt_reg <= 10'h000;
      ram_refresh <= 1'b0;
    end
    else
    begin
      ram_refresh <= (ref_cnt_reg == REF_CYC[9:0] - 10'h001);
      if (ref_cnt_reg == REF_CYC[9:0] - 10'h001)
        ref_cnt_reg <= 10'h000;
      else
        ref_cnt_reg <= ref_cnt_reg + 10'h001;
    end
  end

  // processor answer: wait cycles, parity retry, read data
  reg [2:0] wait_reg;
  reg       busy_reg;
  reg       retried_reg;
  reg       par_fault_reg;
  reg       local_done_reg;
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      wait_reg      <= 3'd0;
      busy_reg      <= 1'b0;
      retried_reg   <= 1'b0;
      local_done_reg <= 1'b0;
      par_fault_reg <= 1'b0;
      cpu_ack       <= 1'b0;
      cpu_rdata     <= 16'h0000;
    end
    else
    begin
      cpu_ack       <= 1'b0;
      par_fault_reg <= 1'b0;
      if (!cpu_strobe)
      begin
        busy_reg    <= 1'b0;
        retried_reg <= 1'b0;
        local_done_reg <= 1'b0;
      end
      else if (!busy_reg && sel_ram)
      begin
        busy_reg <= 1'b1;
        wait_reg <= cpu_write ? `BSIH_WAIT_WR :
                    (parity_enable ? `BSIH_WAIT_RDP : `BSIH_WAIT_RD);
      end
      else if (!busy_reg && !local_done_reg
               && (sel_status || img_sel_reg || (cpu_offboard && grant_s && ack_s)))
      begin
        cpu_ack        <= 1'b1;
        local_done_reg <= 1'b1; // one answer per strobe
      end
      else if (busy_reg && wait_reg != 3'd0)
        wait_reg <= wait_reg - 3'd1;
      else if (busy_reg && !cpu_ack)
      begin
        if (parity_enable && !cpu_write && parity_bad && !retried_reg)
        begin
          retried_reg <= 1'b1;
          wait_reg    <= `BSIH_WAIT_RDP;
        end
        else if (parity_enable && !cpu_write && parity_bad)
          par_fault_reg <= 1'b1;
        else
          cpu_ack <= 1'b1;
        if (!(parity_enable && !cpu_write && parity_bad && !retried_reg))
          busy_reg <= 1'b0;
      end
      if (sel_status)
        cpu_rdata <= board_state;
      else if (img_sel_reg)
        cpu_rdata <= ctrl_reg;
      else if (sel_rom || sel_ram)
        cpu_rdata <= 16'h0000;
    end
  end

  // bus fault: timeout or persistent parity failure
  always @(posedge mclk)
  begin
    if (!resetn)
      bus_fault_signal <= 1'b0;
    else
      bus_fault_signal <= tmo_fault_reg | par_fault_reg;
  end
endmodule

// *** verification/bsih_bp_model.sv ***
// backplane partner: grants the bus and answers acknowledge cycles
// assumes one interrupter; slow stretches both answers
module bsih_bp_model (
  input  wire logic       mclk,
  input  wire logic       slow,
  input  wire logic       own_bus_req,
  input  wire logic       iack_out,
  input  wire logic       slave_ack,
  input  wire logic [7:0] vector,
  output logic            bp_grant_in,
  output logic            bp_ack_n,
  output logic [7:0]      bp_data_in
);
  int   cnt = 0;
  logic answer;
  // quiet lines at time zero
  initial
  begin
    bp_grant_in = 1'b0;
    bp_ack_n = 1'b1;
    bp_data_in = 8'h00;
  end
  // delay count while the block wants the bus
  always @(posedge mclk)
    cnt <= (own_bus_req || iack_out) ? cnt + 1 : 0;
  // grant, acknowledge, vector; released data toggles
  always @(posedge mclk)
  begin
    answer = iack_out && cnt > (slow ? 14 : 3);
    bp_grant_in <= own_bus_req && cnt > (slow ? 12 : 1);
    bp_ack_n <= !(answer || slave_ack);
    bp_data_in <= answer ? vector : ~bp_data_in;
  end
endmodule

// *** verification/bsih_top_checker.sv ***
// assertions on the pins of the backplane control block
// assumes one mclk domain; async pins settle within five edges
module bsih_top_checker #(
  parameter int TMO_BASE = 10
) (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        sysctl_strap,
  input wire logic [6:0]  irq_level_enable,
  input wire logic [2:0]  tmo_select,
  input wire logic [4:0]  bp_req,
  input wire logic        bp_strobe_n,
  input wire logic        bp_ack_n,
  input wire logic        power_fail_line_n,
  input wire logic [15:0] board_state,
  input wire logic        cpu_strobe,
  input wire logic        cpu_write,
  input wire logic [23:0] cpu_addr,
  input wire logic        sys_clk_out,
  input wire logic        host_clk_out,
  input wire logic        bp_reset_n_out,
  input wire logic        bus_fault_signal,
  input wire logic [4:0]  bp_grant_out,
  input wire logic        own_bus_req,
  input wire logic        iack_out,
  input wire logic [2:0]  host_irq_level,
  input wire logic        vector_valid,
  input wire logic        cpu_ack,
  input wire logic        sel_status,
  input wire logic        sel_rom
);
  logic [9:0] run_cnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // length of an unanswered backplane cycle
  always @(posedge mclk)
    if (!resetn || bp_strobe_n || !bp_ack_n || !sysctl_strap || tmo_select[2])
      run_cnt <= 10'h000;
    else
      run_cnt <= run_cnt + 10'h001;
  a_tmo_fires: assert property (run_cnt == (TMO_BASE << tmo_select[1:0]) + 10 |-> bus_fault_signal) else $error("timeout missing");
  a_slave_duties: assert property ((!sysctl_strap)[*4] |-> bp_grant_out == 5'h00 && !sys_clk_out && bp_reset_n_out) else $error("controller duty while not strapped");
  a_grant_top: assert property ((sysctl_strap && bp_req == 5'h1f)[*8] |-> bp_grant_out == 5'h10) else $error("grant not highest");
  a_sysclk_runs: assert property (sysctl_strap[*3] |-> sys_clk_out != $past(sys_clk_out)) else $error("system clock stuck");
  a_host_div: assert property ($rose(host_clk_out) |=> host_clk_out ##1 !host_clk_out [*2] ##1 host_clk_out) else $error("host clock not div4");
  a_bp_reset: assert property ((sysctl_strap && !board_state[0])[*2] |-> !bp_reset_n_out) else $error("backplane reset not driven");
  a_pfail_nmi: assert property ((!power_fail_line_n && irq_level_enable[6])[*8] |-> host_irq_level == 3'h7) else $error("power fail not raised");
  a_vector_end: assert property (vector_valid |=> !vector_valid && !iack_out) else $error("vector pulse wrong");
  a_iack_owned: assert property ($rose(iack_out) |-> $past(own_bus_req)) else $error("acknowledge without request");
  a_ack_cause: assert property (cpu_ack |-> $past(cpu_strobe) ##1 !cpu_ack) else $error("stray cpu ack");
  a_status_addr: assert property (sel_status |-> {$past(cpu_addr[23:1]), 1'b0} == 24'hf70018) else $error("status decode wrong");
  a_rom_nowrite: assert property (sel_rom |-> !$past(cpu_write)) else $error("rom write selected");
  c_vector: cover property (vector_valid);
  c_fault: cover property (bus_fault_signal);
  c_grant: cover property (bp_grant_out == 5'h10);
endmodule
bind bsih_top bsih_top_checker #(.TMO_BASE(TMO_BASE)) bsih_top_checker_inst (.*);

// *** verification/bsih_top_tb.sv ***
// self-checking bench for the backplane control block
// assumes short timeout and refresh counts set below
module bsih_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 10;
  localparam int REF = 40;
  logic        mclk = 1'b0, resetn = 1'b0, sysctl_strap = 1'b0, parity_enable = 1'b0;
  logic        power_fail_line_n = 1'b1, bp_strobe_n = 1'b1, slave_ack = 1'b0, slow = 1'b0;
  logic        cpu_strobe = 1'b0, cpu_write = 1'b0, cpu_offboard = 1'b0, parity_bad = 1'b0;
  logic [6:0]  irq_level_enable = 7'h00, bp_irq_n = 7'h7f;
  logic [2:0]  own_req_level = 3'h5, tmo_select = 3'h0, own_req_lvl_out, iack_level;
  logic [7:0]  ram_base_1k = 8'h04, bp_data_in, irq_vector;
  logic [1:0]  ram_block_256k = 2'h1, cpu_lanes = 2'h3;
  logic [4:0]  bp_req = 5'h00, bp_grant_out, s;
  logic [23:0] bp_addr = 24'h000000, cpu_addr = 24'h000000;
  logic [15:0] cpu_wdata = 16'h0000, board_state = 16'h0001, cpu_rdata;
  logic        bp_grant_in, bp_ack_n, sys_clk_out, host_clk_out, bp_reset_n_out, own_bus_req;
  logic        bus_fault_signal, iack_out, vector_valid, cpu_ack, sel_status, sel_serial;
  logic        sel_timer, sel_rom, rom_socket, sel_ram, ram_refresh, ram_bp_hit;
  logic [2:0]  host_irq_level;
  logic [23:0] pa [6] = '{24'hf70018, 24'hf70010, 24'hf70002, 24'hf08000, 24'hf00000, 24'hf00000};
  logic [4:0]  pe [6] = '{5'h10, 5'h08, 5'h04, 5'h03, 5'h02, 5'h00};
  logic [4:0]  rq [5] = '{5'h01, 5'h03, 5'h06, 5'h1f, 5'h14};
  int          failures = 0, checked = 0, n, w, r, p;
  always #20 mclk = ~mclk;
  bsih_top #(.TMO_BASE(TMO), .REF_CYC(REF)) bsih_top_inst (.*);
  bsih_bp_model bsih_bp_model_inst (.mclk(mclk), .slow(slow), .own_bus_req(own_bus_req),
    .iack_out(iack_out), .slave_ack(slave_ack), .vector(8'h5a), .bp_grant_in(bp_grant_in),
    .bp_ack_n(bp_ack_n), .bp_data_in(bp_data_in));
  task automatic stop_test();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return vector_valid;
      1: return host_irq_level == 3'h7;
      2: return bus_fault_signal;
      3: return cpu_ack;
      4: return own_bus_req;
      5: return ram_refresh;
      6: return ram_bp_hit;
      7: return !own_bus_req;
      default: return bp_grant_out != 5'h00 || sys_clk_out;
    endcase
  endfunction
  task automatic step(input int c);
    repeat (c) @(negedge mclk);
  endtask
  // bounded wait for an output, cycles counted
  task automatic wait_for(input int k, input int lim, output int cnt);
    cnt = 0;
    while (pick(k) !== 1'b1)
    begin
      step(1);
      cnt++;
      if (cnt > lim)
      begin
        failures++;
        $display("BAD at %0t waited %h limit %h", $time, cnt, lim);
        stop_test();
      end
    end
  endtask
  // count cycles in which an output shows high
  task automatic quiet(input int k, input int c, output int hits);
    hits = 0;
    repeat (c)
    begin
      step(1);
      if (pick(k) !== 1'b0)
        hits++;
    end
  endtask
  // processor access held until acknowledged
  task automatic cpu(input logic [23:0] a, input logic wr, input logic [15:0] d, output int cnt);
    cpu_addr = a;
    cpu_write = wr;
    cpu_wdata = d;
    cpu_strobe = 1'b1;
    wait_for(3, 40, cnt);
    cpu_strobe = 1'b0;
    step(1);
  endtask
  // decode probe, ends early on an acknowledge
  task automatic probe(input logic [23:0] a, input logic wr, output logic [4:0] sv);
    cpu_addr = a;
    cpu_write = wr;
    cpu_strobe = 1'b1;
    step(2);
    sv = {sel_status, sel_serial, sel_timer, sel_rom, rom_socket};
    for (int i = 0; i < 12 && cpu_ack !== 1'b1; i++)
      step(1);
    cpu_strobe = 1'b0;
    step(1);
  endtask
  // main sequence
  initial
  begin
    step(2);
    resetn = 1'b1;
    step(6);
    bp_req = 5'h1f;
    bp_strobe_n = 1'b0;
    board_state = 16'h0000;
    quiet(8, 40, n);
    chk(n, 0);
    chk(bp_reset_n_out, 1'b1);
    bp_req = 5'h00;
    bp_strobe_n = 1'b1;
    board_state = 16'h0001;
    $display("test not controller done");
    irq_level_enable = 7'h04;
    bp_irq_n = 7'h7e;
    quiet(4, 30, n);
    chk(n, 0);
    bp_irq_n = 7'h7b;
    slow = 1'b1;
    wait_for(4, 20, n);
    chk(iack_out, 1'b0);
    wait_for(0, 80, n);
    chk(irq_vector, 8'h5a);
    chk(iack_level, 3'h3);
    bp_irq_n = 7'h7f;
    slow = 1'b0;
    power_fail_line_n = 1'b0;
    quiet(1, 20, n);
    chk(n, 0);
    irq_level_enable = 7'h40;
    wait_for(1, 20, n);
    power_fail_line_n = 1'b1;
    $display("test interrupts done");
    sysctl_strap = 1'b1;
    foreach (rq[i])
    begin
      bp_req = 5'h00;
      step(6);
      bp_req = rq[i];
      step(10);
      for (int b = 0; b < 5; b++)
        if (rq[i][b])
          s = 5'h01 << b;
      chk(bp_grant_out, s);
    end
    bp_req = 5'h00;
    n = 0;
    repeat (20)
    begin
      r = sys_clk_out;
      step(1);
      n += (sys_clk_out !== r);
    end
    chk(n, 20);
    board_state = 16'h0000;
    step(3);
    chk(bp_reset_n_out, 1'b0);
    board_state = 16'h0001;
    $display("test controller done");
    for (int t = 0; t < 4; t++)
    begin
      tmo_select = t[2:0];
      step(2);
      bp_strobe_n = 1'b0;
      wait_for(2, (TMO << t) + 12, n);
      chk(n >= (TMO << t), 1'b1);
      step(6);
      bp_strobe_n = 1'b1;
      step(10);
    end
    tmo_select = 3'h0;
    bp_strobe_n = 1'b0;
    step(3);
    slave_ack = 1'b1;
    quiet(2, 40, n);
    chk(n, 0);
    bp_strobe_n = 1'b1;
    slave_ack = 1'b0;
    tmo_select = 3'h4;
    step(10);
    bp_strobe_n = 1'b0;
    quiet(2, 100, n);
    chk(n, 0);
    bp_strobe_n = 1'b1;
    $display("test timeout done");
    board_state = 16'ha5c3;
    foreach (pa[i])
    begin
      probe(pa[i], i == 5, s);
      chk(s, pe[i]);
    end
    cpu(24'hf70018, 1'b0, 16'h0000, n);
    chk(cpu_rdata, 16'ha5c3);
    cpu(24'h01fff0, 1'b0, 16'h0000, n);
    chk(cpu_rdata, 16'h0000);
    cpu(24'h01fff0, 1'b1, 16'h0002, n);
    cpu(24'h01fff0, 1'b0, 16'h0000, n);
    chk(cpu_rdata, 16'h0002);
    cpu(24'h000100, 1'b1, 16'h1234, w);
    cpu(24'h000100, 1'b0, 16'h0000, r);
    parity_bad = 1'b1;
    cpu(24'h000100, 1'b0, 16'h0000, n);
    chk(n, r);
    parity_enable = 1'b1;
    parity_bad = 1'b0;
    cpu(24'h000100, 1'b0, 16'h0000, p);
    chk(p - r, 1);
    chk(r - w >= 1 && r - w <= 3, 1'b1);
    parity_bad = 1'b1;
    cpu_strobe = 1'b1;
    wait_for(2, 40, n);
    chk(sel_ram, 1'b1);
    cpu_strobe = 1'b0;
    parity_bad = 1'b0;
    step(4);
    $display("test decode done");
    wait_for(5, REF + 5, n);
    step(1);
    wait_for(5, REF + 5, n);
    chk(n >= REF - 3 && n <= REF + 1, 1'b1);
    bp_addr = 24'h041000;
    bp_strobe_n = 1'b0;
    wait_for(6, 20, n);
    bp_addr = 24'h081000;
    step(2);
    quiet(6, 20, n);
    chk(n, 0);
    bp_strobe_n = 1'b1;
    cpu_offboard = 1'b1;
    cpu_addr = 24'h300000;
    cpu_strobe = 1'b1;
    wait_for(4, 20, n);
    chk(own_req_lvl_out, own_req_level);
    slave_ack = 1'b1;
    wait_for(3, 40, n);
    cpu_strobe = 1'b0;
    slave_ack = 1'b0;
    wait_for(7, 40, n);
    $display("test ram and request done");
    stop_test();
  end
endmodule
